/* host_port_regs.vh */
// Purpose: constants for the host port command/status fifo block
// Assumes: 5-bit sub-CPU register address, 8-bit data
// Notes:   offsets are register indexes on the plain register port
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH

// read offsets
`define RD_COMMAND_IN_FIFO     5'h00
`define RD_HOST_PORT_FLAGS     5'h01
`define RD_DECODER_VALIDITY    5'h0f
`define RD_SUBCODE_ADDR_HIGH   5'h13
`define RD_HOST_PORT_CONTROL   5'h14
`define RD_PORT_MODE           5'h15
`define RD_ATAPI_COMMAND_REG   5'h1a

// write offsets
`define WR_STATUS_OUT_FIFO     5'h00
`define WR_HOST_PORT_CONTROL   5'h01
`define WR_TRANSFER_TRIGGER    5'h02
`define WR_TRANSFER_END_ACK    5'h03
`define WR_PORT_MODE           5'h15

// host_port_control fields
`define CTL_COMMAND_IRQ_MASK   7
`define CTL_TRANSFER_END_MASK  6
`define CTL_DECODER_IRQ_MASK   5
`define CTL_BREAK_DISABLE      4
`define CTL_DATA_WAIT          3
`define CTL_STATUS_WAIT        2
`define CTL_DATA_OUT_ENABLE    1
`define CTL_STATUS_OUT_ENABLE  0
`define CTL_RESET              8'h00
`define CTL_ATAPI_KEEP         8'he0

// port_mode fields
`define MODE_SEL_HI            1
`define MODE_SEL_LO            0
`define MODE_PACKET_ENABLE     2
`define MODE_ATAPI             2'h2
`define MODE_RESET             3'h0

// misc values
`define FIFO_DEPTH             12
`define EMPTY_READ_VALUE       8'hff
`define DIAG_COMMAND           8'h90
`define ZERO_BYTE              8'h00

`endif

/* host_port_command_status_fifos.v */
// Purpose: host port control between sub-CPU and host: status and command fifos,
//          control and flag registers, interrupt masking, transfer interlocks
// Assumes: host strobes are asynchronous active-low pins, host data stable around them;
//          data engine signals are on clk
// Notes:   no bus wait states; read data valid the cycle after rd
`timescale 1ns/10ps
`include "host_port_regs.vh"

// Functional notes
// - twelve-byte status fifo carries sub-CPU bytes to the host
// - compatibility modes: status fifo write starts a status transfer
// - compatibility, status output enabled: status write drives busy-low flag to zero
// - status wait off: status ready strobe goes low right after a status write
// - status wait on and data-ready flag high: strobe and busy both low
// - wait on, data-ready low: strobe held high until flag rises
// - ATAPI: packet bytes accepted only with packet mode and data transfer started
// - compatibility modes: command register is a twelve-byte host-to-CPU fifo
// - read emptying command fifo clears command flag; later reads return ff
// - reset clears control; in ATAPI only control bits 7..5 act
// - control bits 7..5 mask command, end, decoder flags onto irq pin
// - bit 4 low: host command write breaks transfers, no end interrupt
// - bit 3 low: data transfer waits for status transfer to finish
// - bit 2 set: status transfer waits for data transfer to finish
// - bit 1 enables data transfers; clearing it aborts them
// - bit 0 enables status transfers; clearing it flushes fifo and aborts
// - ATAPI: flag bits 2..0 read zero, only 7..3 meaningful
// - ATAPI: command flag set by selected write or 90h; cleared reading it
// - compatibility: command flag high while command fifo holds bytes
// - end flag set at transfer end, ATAPI packet or memory move; ack clears
// - decoder flag set on new sector, cleared reading decoder validity
// - subcode flag set on new subcode, cleared reading subcode high address
// - data busy set by transfer trigger write, cleared at transfer end
module host_port_command_status_fifos #(
  parameter DEPTH = `FIFO_DEPTH,
  parameter PW    = 4
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst_b,
  // sub-CPU register port
  input  wire [4:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  // host pins
  input  wire       host_cmd_wr_b,
  input  wire       host_stat_rd_b,
  input  wire       host_atapi_command_reg_wr_b,
  input  wire       drive_selected,
  input  wire [7:0] host_din,
  output reg  [7:0] host_dout,
  output reg        status_ready_strobe_b,
  output reg        data_ready_strobe_b,
  // data engine and decoder
  input  wire       transfer_done,
  input  wire       memory_move_done,
  input  wire       sector_ready,
  input  wire       subcode_ready,
  input  wire       decoder_valid,
  output reg        data_abort,
  output wire       data_transfer_busy,
  // sub-CPU interrupt
  output wire       irq
);

  // pin synchroniser: three stages, a change counts when stages 2 and 3 agree
  reg  [3:0] sync1;
  reg  [3:0] sync2;
  reg  [3:0] sync3;
  reg  [3:0] pin_level;
  reg  [3:0] pin_prev;
  wire [3:0] pin_raw = {drive_selected, host_atapi_command_reg_wr_b, host_stat_rd_b, host_cmd_wr_b};

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1     <= 4'h7;
      sync2     <= 4'h7;
      sync3     <= 4'h7;
      pin_level <= 4'h7;
      pin_prev  <= 4'h7;
    end else begin
      sync1     <= pin_raw;
      sync2     <= sync1;
      sync3     <= sync2;
      pin_level <= (sync2 & sync3) | (pin_level & (sync2 ^ sync3));
      pin_prev  <= pin_level;
    end
  end

  // falling edges of the strobes mark host accesses
  wire host_cmd_wr  = pin_prev[0] & ~pin_level[0];
  wire host_stat_rd = pin_prev[1] & ~pin_level[1];
  wire host_atapi_command_reg_wr = pin_prev[2] & ~pin_level[2];
  wire drive_sel    = pin_level[3];

  // control and mode registers
  reg  [7:0] ctrl_raw;
  reg  [2:0] mode;
  wire       atapi   = (mode[`MODE_SEL_HI:`MODE_SEL_LO] == `MODE_ATAPI);
  wire       compat  = ~atapi;
  wire [7:0] ctrl    = atapi ? (ctrl_raw & `CTL_ATAPI_KEEP) : ctrl_raw;

  wire wr_status = wr & (addr == `WR_STATUS_OUT_FIFO);
  wire wr_ctrl   = wr & (addr == `WR_HOST_PORT_CONTROL);
  wire wr_trig   = wr & (addr == `WR_TRANSFER_TRIGGER);
  wire wr_ack    = wr & (addr == `WR_TRANSFER_END_ACK);
  wire wr_mode   = wr & (addr == `WR_PORT_MODE);
  wire rd_cmd    = rd & (addr == `RD_COMMAND_IN_FIFO);
  wire rd_dec    = rd & (addr == `RD_DECODER_VALIDITY);
  wire rd_sub    = rd & (addr == `RD_SUBCODE_ADDR_HIGH);
  wire rd_atapi_command_reg   = rd & (addr == `RD_ATAPI_COMMAND_REG);

  // control writes store all bits; in ATAPI only bits 7..5 act
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_raw <= `CTL_RESET;
      mode     <= `MODE_RESET;
    end else begin
      if (wr_ctrl)
        ctrl_raw <= wdata;
      if (wr_mode)
        mode <= wdata[2:0];
    end
  end

  // aborts from control writes and command break
  wire data_off   = wr_ctrl & ~wdata[`CTL_DATA_OUT_ENABLE] & compat;
  wire status_off = wr_ctrl & ~wdata[`CTL_STATUS_OUT_ENABLE] & compat;
  wire cmd_break  = compat & host_cmd_wr & ~ctrl[`CTL_BREAK_DISABLE];

  // status fifo storage
  reg [7:0]    stat_mem [0:DEPTH-1];
  reg [PW-1:0] stat_wp;
  reg [PW-1:0] stat_rp;
  reg [PW-1:0] stat_cnt;
  wire stat_empty = (stat_cnt == {PW{1'b0}});
  wire stat_full  = (stat_cnt == DEPTH[PW-1:0]);
  wire stat_flush = status_off | cmd_break;
  wire stat_push  = wr_status & ~stat_full;
  wire stat_pop   = host_stat_rd & ~stat_empty & ~status_ready_strobe_b;

  // status fifo pointers; flush drops everything
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_wp  <= {PW{1'b0}};
      stat_rp  <= {PW{1'b0}};
      stat_cnt <= {PW{1'b0}};
    end else if (stat_flush) begin
      stat_wp  <= {PW{1'b0}};
      stat_rp  <= {PW{1'b0}};
      stat_cnt <= {PW{1'b0}};
    end else begin
      if (stat_push)
        stat_wp <= (stat_wp == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : stat_wp + 1'b1;
      if (stat_pop)
        stat_rp <= (stat_rp == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : stat_rp + 1'b1;
      if (stat_push & ~stat_pop)
        stat_cnt <= stat_cnt + 1'b1;
      else if (stat_pop & ~stat_push)
        stat_cnt <= stat_cnt - 1'b1;
    end
  end

  // status fifo data array
  always @(posedge clk) begin
    if (stat_push)
      stat_mem[stat_wp] <= wdata;
  end

  // host sees the fifo head on its data pins
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      host_dout <= `ZERO_BYTE;
    else
      host_dout <= stat_empty ? `ZERO_BYTE : stat_mem[stat_rp];
  end

  // status busy flag, active low: low while a status transfer is pending
  reg status_transfer_busy_b;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      status_transfer_busy_b <= 1'b1;
    else if (compat & wr_status & ctrl[`CTL_STATUS_OUT_ENABLE])
      status_transfer_busy_b <= 1'b0;
    else if (stat_flush | (stat_pop & (stat_cnt == {{(PW-1){1'b0}}, 1'b1})))
      status_transfer_busy_b <= 1'b1;
  end

  // data transfer busy, end flag
  reg data_busy;
  reg end_flag;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      data_busy <= 1'b0;
    else if (wr_trig)
      data_busy <= 1'b1;
    else if (transfer_done | data_off | cmd_break)
      data_busy <= 1'b0;
  end
  assign data_transfer_busy = data_busy;

  // abort pulse to the data engine; command break gives no end flag
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      data_abort <= 1'b0;
    else
      data_abort <= data_busy & (data_off | cmd_break);
  end

  // data and status wait interlocks
  wire data_go   = data_busy & (atapi | (ctrl[`CTL_DATA_OUT_ENABLE] &
                   (ctrl[`CTL_DATA_WAIT] | status_transfer_busy_b)));
  wire stat_wait = ctrl[`CTL_STATUS_WAIT];
  wire stat_go   = compat & ctrl[`CTL_STATUS_OUT_ENABLE] & ~stat_empty &
                   (~stat_wait | data_ready_strobe_b);

  // host strobes, active low
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_ready_strobe_b   <= 1'b1;
      status_ready_strobe_b <= 1'b1;
    end else begin
      data_ready_strobe_b   <= ~(compat & data_go);
      status_ready_strobe_b <= ~stat_go;
    end
  end

  // command fifo: compat always, ATAPI only for packets during a transfer
  wire cmd_accept = compat | (mode[`MODE_PACKET_ENABLE] & data_busy);
  reg [7:0]    cmd_mem [0:DEPTH-1];
  reg [PW-1:0] cmd_wp;
  reg [PW-1:0] cmd_rp;
  reg [PW-1:0] cmd_cnt;
  wire cmd_empty = (cmd_cnt == {PW{1'b0}});
  wire cmd_full  = (cmd_cnt == DEPTH[PW-1:0]);
  wire cmd_push  = host_cmd_wr & cmd_accept & ~cmd_full;
  wire cmd_pop   = rd_cmd & ~cmd_empty;
  wire pkt_done  = atapi & cmd_push & (cmd_cnt == DEPTH[PW-1:0] - 1'b1);

  // command fifo pointers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_wp  <= {PW{1'b0}};
      cmd_rp  <= {PW{1'b0}};
      cmd_cnt <= {PW{1'b0}};
    end else begin
      if (cmd_push)
        cmd_wp <= (cmd_wp == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : cmd_wp + 1'b1;
      if (cmd_pop)
        cmd_rp <= (cmd_rp == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : cmd_rp + 1'b1;
      if (cmd_push & ~cmd_pop)
        cmd_cnt <= cmd_cnt + 1'b1;
      else if (cmd_pop & ~cmd_push)
        cmd_cnt <= cmd_cnt - 1'b1;
    end
  end

  // command fifo data array
  always @(posedge clk) begin
    if (cmd_push)
      cmd_mem[cmd_wp] <= host_din;
  end

  // ATAPI command register and its flag; set wins over the read clear
  reg [7:0] atapi_command_reg;
  reg       atapi_command_reg_flag;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      atapi_command_reg      <= `ZERO_BYTE;
      atapi_command_reg_flag <= 1'b0;
    end else begin
      if (host_atapi_command_reg_wr)
        atapi_command_reg <= host_din;
      if (host_atapi_command_reg_wr & (drive_sel | (host_din == `DIAG_COMMAND)))
        atapi_command_reg_flag <= 1'b1;
      else if (rd_atapi_command_reg)
        atapi_command_reg_flag <= 1'b0;
    end
  end

  // sticky event flags; set wins over clear
  reg dec_flag;
  reg sub_flag;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      end_flag <= 1'b0;
      dec_flag <= 1'b0;
      sub_flag <= 1'b0;
    end else begin
      if (transfer_done & data_busy | atapi & (pkt_done | memory_move_done))
        end_flag <= 1'b1;
      else if (wr_ack)
        end_flag <= 1'b0;
      if (sector_ready)
        dec_flag <= 1'b1;
      else if (rd_dec)
        dec_flag <= 1'b0;
      if (subcode_ready)
        sub_flag <= 1'b1;
      else if (rd_sub)
        sub_flag <= 1'b0;
    end
  end

  // command flag: fifo occupancy in compat, latched flag in ATAPI
  wire cmd_flag = atapi ? atapi_command_reg_flag : ~cmd_empty;

  // flag register view; low bits only in compat
  wire [7:0] flags = {cmd_flag, end_flag, dec_flag, sub_flag, data_busy,
                      compat & ~status_transfer_busy_b,
                      compat & data_ready_strobe_b,
                      compat & status_ready_strobe_b};

  // interrupt pin from masked flags
  assign irq = |(flags[7:5] & ctrl[7:5]);

  // read data, one cycle after the strobe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      rdata <= `ZERO_BYTE;
    else if (rd) begin
      case (addr)
        `RD_COMMAND_IN_FIFO:   rdata <= cmd_empty ? `EMPTY_READ_VALUE : cmd_mem[cmd_rp];
        `RD_HOST_PORT_FLAGS:   rdata <= flags;
        `RD_DECODER_VALIDITY:  rdata <= {decoder_valid, 7'h00};
        `RD_HOST_PORT_CONTROL: rdata <= ctrl_raw;
        `RD_PORT_MODE:         rdata <= {5'h00, mode};
        `RD_ATAPI_COMMAND_REG: rdata <= atapi_command_reg;
        default:               rdata <= `ZERO_BYTE;
      endcase
    end else
      rdata <= `ZERO_BYTE;
  end

endmodule // host_port_command_status_fifos

/* host_port_checker_props.sv */
// Purpose: port-level checks of the host port block
// Assumes: sees only the top ports; control and mode shadowed from writes
// Notes:   one clock domain, async active-low reset
`timescale 1ns/10ps
`include "host_port_regs.vh"
module host_port_checker (
  // clock, reset, register port
  input wire       clk,
  input wire       rst_b,
  input wire [4:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  // watched outputs and engine input
  input wire [7:0] host_dout,
  input wire       status_ready_strobe_b,
  input wire       transfer_done,
  input wire       data_abort,
  input wire       data_transfer_busy,
  input wire       irq
);
  reg  [7:0] ctl;
  reg  [2:0] mode;
  wire       compat = (mode[1:0] != `MODE_ATAPI);
  wire       ctl_wr = wr && (addr == `WR_HOST_PORT_CONTROL);
  // shadow of control and mode registers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl  <= 8'h00;
      mode <= 3'h0;
    end else begin
      if (ctl_wr) ctl <= wdata;
      if (wr && addr == `WR_PORT_MODE) mode <= wdata[2:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ctl_readback:
    assert property (rd && addr == `RD_HOST_PORT_CONTROL |=> rdata == ctl)
    else $error("control readback differs");
  a_irq_needs_mask:
    assert property (irq |-> ctl[7:5] != 3'h0) else $error("irq with all masks off");
  a_trigger_sets_busy:
    assert property (wr && addr == `WR_TRANSFER_TRIGGER && compat && ctl[1]
                     && status_ready_strobe_b |=> data_transfer_busy)
    else $error("trigger did not set busy");
  a_disable_aborts:
    assert property (ctl_wr && !wdata[1] && compat && data_transfer_busy && !transfer_done
                     |=> data_abort ##1 !data_abort)
    else $error("data disable did not abort");
  a_abort_cause:
    assert property (data_abort |-> $past(data_transfer_busy)) else $error("abort while idle");
  a_done_clears_busy:
    assert property (transfer_done && data_transfer_busy && !wr |=> !data_transfer_busy)
    else $error("busy stuck after done");
  a_status_flush:
    assert property (ctl_wr && !wdata[0] && compat
                     |-> ##[1:3] (status_ready_strobe_b && host_dout == 8'h00))
    else $error("status fifo not flushed");
  a_status_ready:
    assert property (wr && addr == `WR_STATUS_OUT_FIFO && compat && ctl[0] && !ctl[2]
                     && status_ready_strobe_b |-> ##[1:3] !status_ready_strobe_b)
    else $error("status strobe did not fall");
  a_rdata_idle:
    assert property (!rd |=> rdata == 8'h00) else $error("read data outside slot");
endmodule // host_port_checker

bind host_port_command_status_fifos host_port_checker chk (
  .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .host_dout(host_dout), .status_ready_strobe_b(status_ready_strobe_b),
  .transfer_done(transfer_done), .data_abort(data_abort),
  .data_transfer_busy(data_transfer_busy), .irq(irq));

/* host_model.sv */
// Purpose: host computer side of the parallel drive port
// Assumes: strobes low six cycles, high six cycles
// Notes:   released data shows the inverse of the last byte
`timescale 1ns/10ps
module host_model (
  // clock and device data
  input  wire       clk,
  input  wire [7:0] host_dout,
  // host strobes and data
  output reg        host_cmd_wr_b,
  output reg        host_stat_rd_b,
  output reg        host_atapi_command_reg_wr_b,
  output reg        drive_selected,
  output reg  [7:0] host_din
);
  // idle pins
  initial begin
    host_cmd_wr_b  = 1'b1;
    host_stat_rd_b = 1'b1;
    host_atapi_command_reg_wr_b = 1'b1;
    drive_selected = 1'b0;
    host_din       = 8'h00;
  end
  // one strobe: 0 command write, 1 atapi command, 2 status read
  task pulse(input int which, input logic [7:0] b);
    begin
      @(posedge clk);
      host_din <= b;
      host_cmd_wr_b <= (which != 0);
      host_atapi_command_reg_wr_b <= (which != 1);
      host_stat_rd_b <= (which != 2);
      repeat (6) @(posedge clk);
      host_cmd_wr_b <= 1'b1;
      host_atapi_command_reg_wr_b <= 1'b1;
      host_stat_rd_b <= 1'b1;
      host_din <= ~b;
      repeat (6) @(posedge clk);
      #1;
    end
  endtask
endmodule // host_model

/* tb_host_port_command_status_fifos.sv */
// Purpose: self-checking bench of the host port block
// Assumes: host_model on the host pins, register port driven here
// Notes:   fixed seed random bytes with corner cases
`timescale 1ns/10ps
`include "host_port_regs.vh"
module tb_host_port_command_status_fifos;
  reg         clk, rst_b, wr, rd, transfer_done, memory_move_done;
  reg         sector_ready, subcode_ready, decoder_valid;
  reg   [4:0] addr;
  reg   [7:0] wdata;
  wire  [7:0] rdata, host_din, host_dout;
  wire        host_cmd_wr_b, host_stat_rd_b, host_atapi_command_reg_wr_b, drive_selected;
  wire        status_ready_strobe_b, data_ready_strobe_b, data_abort, data_transfer_busy, irq;
  int         bad_count, total_checks, i;
  logic [7:0] v, q[$];

  host_port_command_status_fifos dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .host_cmd_wr_b(host_cmd_wr_b),
    .host_stat_rd_b(host_stat_rd_b), .host_atapi_command_reg_wr_b(host_atapi_command_reg_wr_b),
    .drive_selected(drive_selected), .host_din(host_din), .host_dout(host_dout),
    .status_ready_strobe_b(status_ready_strobe_b), .data_ready_strobe_b(data_ready_strobe_b),
    .transfer_done(transfer_done), .memory_move_done(memory_move_done),
    .sector_ready(sector_ready), .subcode_ready(subcode_ready),
    .decoder_valid(decoder_valid), .data_abort(data_abort),
    .data_transfer_busy(data_transfer_busy), .irq(irq));
  host_model hm (.clk(clk), .host_dout(host_dout), .host_cmd_wr_b(host_cmd_wr_b),
    .host_stat_rd_b(host_stat_rd_b), .host_atapi_command_reg_wr_b(host_atapi_command_reg_wr_b),
    .drive_selected(drive_selected), .host_din(host_din));

  // compare and count
  task chk(input logic [7:0] got, input logic [7:0] exp);
    begin
      total_checks++;
      if (got !== exp) begin
        bad_count++;
        $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // register port write and read
  task wreg(input logic [4:0] a, input logic [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rreg(input logic [4:0] a, output logic [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
    end
  endtask
  task cyc(input int n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task report_and_stop;
    begin
      $display("checks=%0d bad=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard
  initial begin
    #500000;
    bad_count++;
    report_and_stop;
  end
  // main sequence
  initial begin
    rst_b = 1'b0; wr = 1'b0; rd = 1'b0; addr = 5'h00; wdata = 8'h00;
    transfer_done = 1'b0; memory_move_done = 1'b0; sector_ready = 1'b0;
    subcode_ready = 1'b0; decoder_valid = 1'b0;
    v = 8'($urandom(32'h8f73922e));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rreg(`RD_HOST_PORT_CONTROL, v);
    chk(v, `CTL_RESET);
    chk(irq, 0);
    // command fifo filled past depth, then drained
    for (i = 0; i < 13; i++) begin
      v = 8'($urandom);
      if (i < 12) q.push_back(v);
      hm.pulse(0, v);
    end
    rreg(`RD_HOST_PORT_FLAGS, v);
    chk(v[7], 1);
    for (i = 0; i < 12; i++) begin
      rreg(`RD_COMMAND_IN_FIFO, v);
      chk(v, q.pop_front());
    end
    rreg(`RD_COMMAND_IN_FIFO, v);
    chk(v, `EMPTY_READ_VALUE);
    rreg(`RD_HOST_PORT_FLAGS, v);
    chk(v[7], 0);
    // status fifo filled past depth, host pops in order
    wreg(`WR_HOST_PORT_CONTROL, 8'h03);
    for (i = 0; i < 13; i++) begin
      v = 8'($urandom);
      if (i < 12) q.push_back(v);
      wreg(`WR_STATUS_OUT_FIFO, v);
    end
    cyc(3);
    chk(status_ready_strobe_b, 0);
    for (i = 0; i < 12; i++) begin
      chk(host_dout, q.pop_front());
      hm.pulse(2, 8'h00);
    end
    chk(status_ready_strobe_b, 1);
    // status disable empties a part-filled fifo
    wreg(`WR_STATUS_OUT_FIFO, 8'h5a);
    wreg(`WR_STATUS_OUT_FIFO, 8'ha5);
    wreg(`WR_HOST_PORT_CONTROL, 8'h02);
    cyc(3);
    chk(status_ready_strobe_b, 1);
    chk(host_dout, 8'h00);
    // decoder and subcode flags; decoder flag masked then unmasked
    @(posedge clk) sector_ready <= 1'b1;
    subcode_ready <= 1'b1;
    decoder_valid <= 1'($urandom);
    @(posedge clk) sector_ready <= 1'b0;
    subcode_ready <= 1'b0;
    cyc(2);
    chk(irq, 0);
    wreg(`WR_HOST_PORT_CONTROL, 8'h22);
    cyc(1);
    chk(irq, 1);
    rreg(`RD_HOST_PORT_FLAGS, v);
    chk(v[5:4], 2'h3);
    rreg(`RD_DECODER_VALIDITY, v);
    rreg(`RD_SUBCODE_ADDR_HIGH, v);
    rreg(`RD_HOST_PORT_FLAGS, v);
    chk(v[5:4], 2'h0);
    chk(irq, 0);
    // data wait on: data strobe held while a status byte is pending
    wreg(`WR_HOST_PORT_CONTROL, 8'h03);
    wreg(`WR_STATUS_OUT_FIFO, 8'h11);
    wreg(`WR_TRANSFER_TRIGGER, 8'h00);
    cyc(3);
    chk(data_ready_strobe_b, 1);
    wreg(`WR_HOST_PORT_CONTROL, 8'h02);
    cyc(2);
    chk(data_ready_strobe_b, 0);
    // data transfer ends by done, by disable, by command break
    for (i = 0; i < 3; i++) begin
      wreg(`WR_HOST_PORT_CONTROL, (i == 0) ? 8'h5a : 8'h4a);
      wreg(`WR_TRANSFER_TRIGGER, 8'($urandom));
      cyc(2);
      chk(data_transfer_busy, 1);
      chk(data_ready_strobe_b, 0);
      if (i == 0) begin
        @(posedge clk) transfer_done <= 1'b1;
        @(posedge clk) transfer_done <= 1'b0;
      end else if (i == 1)
        wreg(`WR_HOST_PORT_CONTROL, 8'h48);
      else
        hm.pulse(0, 8'($urandom));
      cyc(2);
      chk(data_transfer_busy, 0);
      rreg(`RD_HOST_PORT_FLAGS, v);
      chk(v[6], i == 0);
      chk(irq, i == 0);
      wreg(`WR_TRANSFER_END_ACK, 8'h00);
      cyc(1);
      chk(irq, 0);
    end
    // drain the byte left by the command break
    rreg(`RD_COMMAND_IN_FIFO, v);
    rreg(`RD_COMMAND_IN_FIFO, v);
    chk(v, `EMPTY_READ_VALUE);
    // atapi: diagnostic command with drive not selected, memory move
    wreg(`WR_PORT_MODE, 8'h02);
    hm.pulse(1, `DIAG_COMMAND);
    rreg(`RD_HOST_PORT_FLAGS, v);
    chk(v[7], 1);
    chk(v[1:0], 2'h0);
    rreg(`RD_ATAPI_COMMAND_REG, v);
    rreg(`RD_HOST_PORT_FLAGS, v);
    chk(v[7], 0);
    @(posedge clk) memory_move_done <= 1'b1;
    @(posedge clk) memory_move_done <= 1'b0;
    rreg(`RD_HOST_PORT_FLAGS, v);
    chk(v[6], 1);
    wreg(`WR_TRANSFER_END_ACK, 8'h00);
    // atapi without packet enable refuses host command bytes
    hm.pulse(0, 8'h3c);
    rreg(`RD_COMMAND_IN_FIFO, v);
    chk(v, `EMPTY_READ_VALUE);
    // packet enable and transfer started: twelve bytes, end flag on the last
    wreg(`WR_PORT_MODE, 8'h06);
    wreg(`WR_TRANSFER_TRIGGER, 8'h00);
    for (i = 0; i < 12; i++) begin
      v = 8'($urandom);
      q.push_back(v);
      hm.pulse(0, v);
      if (i == 10) begin
        rreg(`RD_HOST_PORT_FLAGS, v);
        chk(v[6], 0);
      end
    end
    rreg(`RD_HOST_PORT_FLAGS, v);
    chk(v[6], 1);
    for (i = 0; i < 12; i++) begin
      rreg(`RD_COMMAND_IN_FIFO, v);
      chk(v, q.pop_front());
    end
    report_and_stop;
  end
endmodule // tb_host_port_command_status_fifos
